// ### rtl/card_socket_control_regs.sv
`timescale 1ns/1ps
`include "card_socket_defs.svh"
module card_socket_control_regs (
    input  wire logic        CLOCK_I,
    input  wire logic        RST_N_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [5:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        CARD_DETECT_A_N_I,
    input  wire logic        CARD_DETECT_B_N_I,
    input  wire logic        CARD_VOLTAGE_SENSE_A_I,
    input  wire logic        CARD_VOLTAGE_SENSE_B_I,
    input  wire logic        WIDE_WINDOW_I,
    input  wire logic        STROBE_WE_N_I,
    input  wire logic        STROBE_OE_N_I,
    output logic             STROBE_WE_N_O,
    output logic             STROBE_OE_N_O,
    output logic             CONFIG_RESET_O,
    output logic             SUPPLY_5V_SWITCH_N_O,
    output logic             SUPPLY_3V_SWITCH_N_O,
    output logic             IRQ_O
);

    // -----------------------------------------------------------------
    // Reset release and pin synchronisers
    // -----------------------------------------------------------------
    logic [1:0] rst_sync;
    logic       rst_n;
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic       cd_both_q;

    // Reset is asserted at once but released through two flops
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Card pins come from outside the clock domain; detects reset to their
    // pulled-up idle level so an empty slot gives no false removal edge
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 4'h3;
            pin_sync <= 4'h3;
        end else begin
            pin_meta <= {CARD_VOLTAGE_SENSE_B_I, CARD_VOLTAGE_SENSE_A_I,
                         CARD_DETECT_B_N_I, CARD_DETECT_A_N_I};
            pin_sync <= pin_meta;
        end
    end

    // -----------------------------------------------------------------
    // Bus decode
    // -----------------------------------------------------------------
    card_socket_pkg::wb_req_s req;
    logic                     access;
    logic                     wr;
    logic                     rd;

    assign req    = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I,
                      adr: WB_ADR_I, sel: WB_SEL_I, dat: WB_DAT_I};
    // Ack is one cycle; the gap on ack keeps a held request from firing twice
    assign access = req.cyc && req.stb && !WB_ACK_O;
    assign wr     = access && req.we && req.sel[0];
    assign rd     = access && !req.we;

    // -----------------------------------------------------------------
    // Removal detect and configuration reset pulse
    // -----------------------------------------------------------------
    logic cd_both;
    logic removal;
    logic [7:0] misc_ctrl;
    logic [7:0] global_ctrl;

    assign cd_both = pin_sync[0] && pin_sync[1];
    assign removal = cd_both && !cd_both_q;

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            cd_both_q <= 1'b1;
        end else begin
            cd_both_q <= cd_both;
        end
    end

    // One-clock pulse to the slot's window and control registers
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            CONFIG_RESET_O <= 1'b0;
        end else begin
            CONFIG_RESET_O <= removal
                && misc_ctrl[`BIT_CFG_RST_EN];
        end
    end

    // -----------------------------------------------------------------
    // Control registers
    // -----------------------------------------------------------------
    logic [1:0] supply_sel;
    logic       power_en;

    // Only defined bits are stored, so reserved writes are lost
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            misc_ctrl   <= `RST_MISC_CTRL;
            global_ctrl <= `RST_GLOBAL_CTRL;
            supply_sel  <= `RST_SUPPLY_SEL;
            power_en    <= 1'b0;
        end else if (wr) begin
            case (req.adr)
                `OFF_MISC_CTRL:
                    misc_ctrl   <= {6'h00, req.dat[1:0]};
                `OFF_GLOBAL_CTRL:
                    global_ctrl <= {5'h00, req.dat[2], 2'h0};
                `OFF_SUPPLY_SEL:
                    supply_sel  <= req.dat[1:0];
                `OFF_POWER_ENABLE:
                    power_en    <= req.dat[0];
                default: ;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Card status change and interrupt
    // -----------------------------------------------------------------
    logic       chg_detect;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic       expl_ack;
    logic       chg_event;
    logic       chg_clr;
    logic [1:0] ev;
    logic [1:0] ev_clr;

    assign expl_ack  = global_ctrl[`BIT_EXPL_ACK];
    assign chg_event = cd_both != cd_both_q;
    // Read clears only in implicit mode; write-one clears only explicitly
    assign chg_clr = (req.adr == `OFF_STATUS_CHG) &&
        ((rd && !expl_ack)
         || (wr && expl_ack && req.dat[`BIT_CHG_DETECT]));

    // A change in the same cycle as the clear wins
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            chg_detect <= 1'b0;
        end else if (chg_event) begin
            chg_detect <= 1'b1;
        end else if (chg_clr) begin
            chg_detect <= 1'b0;
        end
    end

    assign ev     = {chg_event, removal};
    assign ev_clr = (wr && req.adr == `OFF_IRQ_STATUS) ?
                    req.dat[1:0] : 2'h0;

    // Sticky events, write one to clear, set beats clear
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= `RST_IRQ;
            irq_mask   <= `RST_IRQ;
        end else begin
            irq_status <= ev | (irq_status & ~ev_clr);
            if (wr && req.adr == `OFF_IRQ_MASK) begin
                irq_mask <= req.dat[1:0];
            end
        end
    end

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(irq_status & irq_mask);
        end
    end

    // -----------------------------------------------------------------
    // Strobe falling-edge delay
    // -----------------------------------------------------------------
    logic we_q;
    logic oe_q;
    logic delay_on;

    assign delay_on = WIDE_WINDOW_I && !misc_ctrl[`BIT_DELAY_INH];

    // Strobes are in this clock's domain; delay only the fall
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            we_q          <= 1'b1;
            oe_q          <= 1'b1;
            STROBE_WE_N_O <= 1'b1;
            STROBE_OE_N_O <= 1'b1;
        end else begin
            we_q <= STROBE_WE_N_I;
            oe_q <= STROBE_OE_N_I;
            if (delay_on) begin
                STROBE_WE_N_O <= STROBE_WE_N_I | we_q;
                STROBE_OE_N_O <= STROBE_OE_N_I | oe_q;
            end else begin
                STROBE_WE_N_O <= STROBE_WE_N_I;
                STROBE_OE_N_O <= STROBE_OE_N_I;
            end
        end
    end

    // -----------------------------------------------------------------
    // Supply switch pins
    // -----------------------------------------------------------------
    card_socket_pkg::supply_pins_s pins;

    always_comb begin
        pins = '{sw5_n: 1'b1, sw3_n: 1'b1};
        if (power_en) begin
            case (card_socket_pkg::supply_e'(supply_sel))
                card_socket_pkg::SUPPLY_5V:
                    pins = '{sw5_n: 1'b0, sw3_n: 1'b1};
                card_socket_pkg::SUPPLY_3V_A,
                card_socket_pkg::SUPPLY_3V_B:
                    pins = '{sw5_n: 1'b1, sw3_n: 1'b0};
                default:
                    pins = '{sw5_n: 1'b1, sw3_n: 1'b1};
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            SUPPLY_5V_SWITCH_N_O <= 1'b1;
            SUPPLY_3V_SWITCH_N_O <= 1'b1;
        end else begin
            SUPPLY_5V_SWITCH_N_O <= pins.sw5_n;
            SUPPLY_3V_SWITCH_N_O <= pins.sw3_n;
        end
    end

    // -----------------------------------------------------------------
    // Read data and ack
    // -----------------------------------------------------------------
    logic [31:0] rdata;

    // Unmapped addresses read zero and still ack
    always_comb begin
        rdata = 32'h0;
        case (req.adr)
            `OFF_MISC_CTRL:    rdata = {24'h0, misc_ctrl};
            `OFF_GLOBAL_CTRL:  rdata = {24'h0, global_ctrl};
            `OFF_VSENSE:       rdata = {30'h0, pin_sync[3:2]};
            `OFF_SUPPLY_SEL:   rdata = {30'h0, supply_sel};
            `OFF_STATUS_CHG:   rdata = {31'h0, chg_detect};
            `OFF_IRQ_STATUS:   rdata = {30'h0, irq_status};
            `OFF_IRQ_MASK:     rdata = {30'h0, irq_mask};
            `OFF_POWER_ENABLE: rdata = {31'h0, power_en};
            default:           rdata = 32'h0;
        endcase
    end

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0;
        end else begin
            WB_ACK_O <= access;
            WB_DAT_O <= rd ? rdata : 32'h0;
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    sequence s_removal_armed;
        removal && misc_ctrl[`BIT_CFG_RST_EN];
    endsequence

    a_removal_reset_pulse: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        s_removal_armed |=> CONFIG_RESET_O ##1 !CONFIG_RESET_O)
        else $error("removal reset pulse wrong");

    a_no_reset_disabled: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        CONFIG_RESET_O |-> $past(misc_ctrl[`BIT_CFG_RST_EN]))
        else $error("reset pulse while disabled");

    a_strobe_fall_delay: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        (delay_on && $fell(STROBE_WE_N_I) && we_q) |=> STROBE_WE_N_O)
        else $error("wide strobe fall not delayed");

    a_strobe_no_delay: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        !delay_on |=> STROBE_OE_N_O == $past(STROBE_OE_N_I))
        else $error("strobe delayed while inhibited");

    a_read_clears_chg: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        (rd && req.adr == `OFF_STATUS_CHG && !expl_ack && !chg_event)
        |=> !chg_detect)
        else $error("read did not clear status change");

    a_explicit_holds: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        (chg_detect && expl_ack && !wr) |=> chg_detect)
        else $error("status change lost without write");

    a_sense_readback: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        (rd && req.adr == `OFF_VSENSE)
        |=> WB_DAT_O == {30'h0, $past(pin_sync[3:2])})
        else $error("sense readback wrong");

    a_supply_off_pins: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        !power_en |=> SUPPLY_5V_SWITCH_N_O && SUPPLY_3V_SWITCH_N_O)
        else $error("supply on without power enable");

    a_supply_5v_pins: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        (power_en && supply_sel == 2'h0)
        |=> !SUPPLY_5V_SWITCH_N_O && SUPPLY_3V_SWITCH_N_O)
        else $error("5v choice pins wrong");

    a_ack_one_cycle: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");

endmodule : card_socket_control_regs

// ### rtl/card_socket_defs.svh
`ifndef CARD_SOCKET_DEFS_SVH
`define CARD_SOCKET_DEFS_SVH

// ---------------------------------------------------------------------
// Register byte offsets (one aligned 32-bit word each)
// ---------------------------------------------------------------------
`define OFF_MISC_CTRL    6'h00
`define OFF_GLOBAL_CTRL  6'h04
`define OFF_VSENSE       6'h08
`define OFF_SUPPLY_SEL   6'h0c
`define OFF_STATUS_CHG   6'h10
`define OFF_IRQ_STATUS   6'h14
`define OFF_IRQ_MASK     6'h18
`define OFF_POWER_ENABLE 6'h1c

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define BIT_DELAY_INH    0
`define BIT_CFG_RST_EN   1
`define BIT_EXPL_ACK     2
`define BIT_CHG_DETECT   0
`define BIT_EV_REMOVAL   0
`define BIT_EV_CHANGE    1

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define RST_MISC_CTRL    8'h00
`define RST_GLOBAL_CTRL  8'h00
`define RST_SUPPLY_SEL   2'h0
`define RST_IRQ          2'h0

`endif

// ### rtl/card_socket_pkg.sv
package card_socket_pkg;

    // Wishbone request as seen by the slave
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [5:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_s;

    // Supply choice codes
    typedef enum logic [1:0] {
        SUPPLY_5V   = 2'b00,
        SUPPLY_3V_A = 2'b01,
        SUPPLY_OFF  = 2'b10,
        SUPPLY_3V_B = 2'b11
    } supply_e;

    // Supply switch pin pair, both active low
    typedef struct packed {
        logic sw5_n;
        logic sw3_n;
    } supply_pins_s;

endpackage : card_socket_pkg

// ### tb/card_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// Card in the socket: detect and voltage sense pins
// ---------------------------------------------------------------------
module card_model (
    input  wire logic       present_i,
    input  wire logic [1:0] sense_code_i,
    output logic            detect_a_n_o,
    output logic            detect_b_n_o,
    output logic            sense_a_o,
    output logic            sense_b_o
);
    // Detect pins are pulled up on the socket, so an empty slot reads high
    assign detect_a_n_o = !present_i;
    assign detect_b_n_o = !present_i;
    // Sense pins float to their pull-ups without a card
    assign sense_a_o = present_i ? sense_code_i[0] : 1'b1;
    assign sense_b_o = present_i ? sense_code_i[1] : 1'b1;
endmodule : card_model

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "card_socket_defs.svh"
module testbench;
    logic                     clk;
    logic                     rst_n;
    card_socket_pkg::wb_req_s req;
    logic [31:0]              dat_o;
    logic                     ack;
    logic                     present;
    logic [1:0]               code;
    logic                     det_a_n, det_b_n, vs_a, vs_b;
    logic                     wide, we_in, oe_in, we_out, oe_out;
    logic                     cfg_rst, sw5_n, sw3_n, irq;
    logic [31:0]              scratch;
    int                       bad_count, comparisons, pulses;

    card_socket_control_regs u_card_socket_control_regs (
        .CLOCK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(req.cyc),
        .WB_STB_I(req.stb), .WB_WE_I(req.we), .WB_ADR_I(req.adr),
        .WB_SEL_I(req.sel), .WB_DAT_I(req.dat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .CARD_DETECT_A_N_I(det_a_n),
        .CARD_DETECT_B_N_I(det_b_n), .CARD_VOLTAGE_SENSE_A_I(vs_a),
        .CARD_VOLTAGE_SENSE_B_I(vs_b), .WIDE_WINDOW_I(wide),
        .STROBE_WE_N_I(we_in), .STROBE_OE_N_I(oe_in),
        .STROBE_WE_N_O(we_out), .STROBE_OE_N_O(oe_out),
        .CONFIG_RESET_O(cfg_rst), .SUPPLY_5V_SWITCH_N_O(sw5_n),
        .SUPPLY_3V_SWITCH_N_O(sw3_n), .IRQ_O(irq));

    card_model u_card_model (
        .present_i(present), .sense_code_i(code), .detect_a_n_o(det_a_n),
        .detect_b_n_o(det_b_n), .sense_a_o(vs_a), .sense_b_o(vs_b));

    // Clock and pulse counter
    initial clk = 1'b0;
    always #20 clk = ~clk;
    always @(posedge clk) begin
        if (cfg_rst === 1'b1) pulses <= pulses + 1;
    end

    // ---------------------------------------------------------------------
    // Bus and compare tasks
    // ---------------------------------------------------------------------
    task check_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: reg got %h exp %h", $time, got, exp);
        end
    endtask : check_reg

    task check_pin(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %b", $time, what, got);
        end
    endtask : check_pin

    // Holds the request until ack is sampled high; the wait is bounded
    task wb_cycle(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        scratch = dat_o;
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
        check_pin(n < 20, 1'b1, "ack");
    endtask : wb_cycle

    task wr(input logic [5:0] a, input logic [31:0] d);
        wb_cycle(1'b1, a, d);
    endtask : wr

    task rd(input logic [5:0] a, input logic [31:0] exp);
        wb_cycle(1'b0, a, 32'h0);
        check_reg(scratch, exp);
    endtask : rd

    task pins(input logic e5, input logic e3);
        repeat (2) @(posedge clk);
        check_pin(sw5_n, e5, "sw5");
        check_pin(sw3_n, e3, "sw3");
    endtask : pins

    // A delayed fall is still high one cycle after the input drops
    task strobe(input logic inh, input logic wide_v, input logic first);
        wr(`OFF_MISC_CTRL, {31'h0, inh});
        wide <= wide_v;
        @(posedge clk);
        we_in <= 1'b0;
        oe_in <= 1'b0;
        @(posedge clk);
        #1 check_pin(we_out, first, "we first");
        check_pin(oe_out, first, "oe first");
        @(posedge clk);
        #1 check_pin(we_out, 1'b0, "we low");
        @(posedge clk);
        we_in <= 1'b1;
        oe_in <= 1'b1;
        @(posedge clk);
        #1 check_pin(oe_out, 1'b1, "oe rise");
    endtask : strobe

    task stop_test;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    // ---------------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------------
    initial begin
        bad_count = 0;
        comparisons = 0;
        pulses = 0;
        rst_n = 1'b0;
        req = '0;
        present = 1'b1;
        code = 2'h0;
        wide = 1'b0;
        we_in = 1'b1;
        oe_in = 1'b1;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        rd(`OFF_MISC_CTRL, 32'h0);
        rd(`OFF_GLOBAL_CTRL, 32'h0);
        rd(`OFF_SUPPLY_SEL, 32'h0);
        pins(1'b1, 1'b1);
        rd(`OFF_STATUS_CHG, 32'h1);
        rd(`OFF_STATUS_CHG, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            code <= i[1:0];
            repeat (4) @(posedge clk);
            rd(`OFF_VSENSE, {30'h0, i[1:0]});
        end
        wr(`OFF_VSENSE, 32'h0);
        rd(`OFF_VSENSE, 32'h3);
        $display("test voltage sense done");
        wr(`OFF_POWER_ENABLE, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(`OFF_SUPPLY_SEL, {30'h0, i[1:0]});
            pins(i != 0, i == 0 || i == 2);
        end
        wr(`OFF_SUPPLY_SEL, 32'hff);
        rd(`OFF_SUPPLY_SEL, 32'h3);
        wr(`OFF_POWER_ENABLE, 32'h0);
        pins(1'b1, 1'b1);
        $display("test supply select done");
        strobe(1'b0, 1'b1, 1'b1);
        strobe(1'b1, 1'b1, 1'b0);
        strobe(1'b0, 1'b0, 1'b0);
        $display("test strobe delay done");
        wr(`OFF_MISC_CTRL, 32'h2);
        present <= 1'b0;
        repeat (10) @(posedge clk);
        check_reg(pulses, 32'h1);
        present <= 1'b1;
        repeat (10) @(posedge clk);
        wr(`OFF_MISC_CTRL, 32'h0);
        present <= 1'b0;
        repeat (10) @(posedge clk);
        check_reg(pulses, 32'h1);
        $display("test removal reset done");
        rd(`OFF_STATUS_CHG, 32'h1);
        wr(`OFF_GLOBAL_CTRL, 32'hff);
        rd(`OFF_GLOBAL_CTRL, 32'h4);
        present <= 1'b1;
        repeat (10) @(posedge clk);
        rd(`OFF_STATUS_CHG, 32'h1);
        rd(`OFF_STATUS_CHG, 32'h1);
        wr(`OFF_STATUS_CHG, 32'h1);
        rd(`OFF_STATUS_CHG, 32'h0);
        $display("test explicit acknowledge done");
        // Events are pending but masked, so the line must stay low
        check_pin(irq, 1'b0, "irq masked");
        rd(`OFF_IRQ_STATUS, 32'h3);
        wr(`OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk);
        check_pin(irq, 1'b1, "irq raised");
        wr(`OFF_IRQ_STATUS, 32'h3);
        repeat (2) @(posedge clk);
        check_pin(irq, 1'b0, "irq cleared");
        rd(`OFF_IRQ_STATUS, 32'h0);
        rd(6'h20, 32'h0);
        $display("test interrupt done");
        stop_test();
    end

    // Whole run needs about 220 cycles; allow plenty of margin
    initial begin
        repeat (6000) @(posedge clk);
        bad_count++;
        stop_test();
    end
endmodule : testbench
